// ===== rtl/sbpg_pkg.sv
package sbpg_pkg;

    localparam int unsigned ADDR_W = 8;

    // register byte addresses on the bus
    localparam logic [7:0] OFS_PIN_FUNCTION  = 8'h00;
    localparam logic [7:0] OFS_PIN_DIRECTION = 8'h04;
    localparam logic [7:0] OFS_PIN_LEVEL_IN  = 8'h08;
    localparam logic [7:0] OFS_PIN_DRIVE_OUT = 8'h0c;
    localparam logic [7:0] OFS_DRIVE_SET     = 8'h10;
    localparam logic [7:0] OFS_DRIVE_CLEAR   = 8'h14;

    // field positions
    localparam int unsigned BIT_CLOCK_LINE = 0;
    localparam int unsigned BIT_DATA_LINE  = 1;
    localparam int unsigned BIT_GPIO_MODE  = 0;

    // reset values
    localparam logic [1:0] RST_DIRECTION = 2'h0;
    localparam logic [1:0] RST_DRIVE     = 2'h0;
    localparam logic       RST_GPIO_MODE = 1'h0;

    // pin level seen before the first sample; an idle bus line floats high
    localparam logic [1:0] RST_PIN_LEVEL = 2'h3;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD    = 3'h2;

    typedef enum logic [2:0] {
        SBPG_SEL_FUNCTION,
        SBPG_SEL_DIRECTION,
        SBPG_SEL_LEVEL_IN,
        SBPG_SEL_DRIVE_OUT,
        SBPG_SEL_DRIVE_SET,
        SBPG_SEL_DRIVE_CLEAR,
        SBPG_SEL_NONE
    } sbpg_sel_t;

    // one pin's drive side, split in two (out and oe_n) for a two-way wire
    typedef struct packed {
        logic out;
        logic oe_n;
    } sbpg_pin_drv_t;

    // pending write taken from an address phase
    typedef struct packed {
        logic      valid;
        sbpg_sel_t sel;
    } sbpg_wr_t;

endpackage

// ===== rtl/sbpg_sync.sv
`timescale 1ns/1ns
module sbpg_sync
#(
    parameter int unsigned WIDTH = 2
)
(
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;

    // first stage feeds only the second stage
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            meta_reg <= sbpg_pkg::RST_PIN_LEVEL;
            sync_out <= sbpg_pkg::RST_PIN_LEVEL;
        end
        else
        begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule

// ===== rtl/sbpg_pin_drv.sv
`timescale 1ns/1ns
module sbpg_pin_drv
(
    input  wire logic                    hclk,
    input  wire logic                    hresetn,
    input  wire logic                    gpio_mode,
    input  wire logic                    dir_out,
    input  wire logic                    drive_bit,
    output sbpg_pkg::sbpg_pin_drv_t      pin
);

    // registered so the pin changes one edge after its controls
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pin.out  <= 1'b0;
            pin.oe_n <= 1'b1;
        end
        else
        begin
            pin.out  <= drive_bit;
            // drive only in gpio mode with direction out; else release
            pin.oe_n <= !(gpio_mode && dir_out);
        end
    end

endmodule

// ===== rtl/sbpg_top.sv
// Added by the designer: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ns
module sbpg_top
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        data_line_in,
    input  wire logic        clock_line_in,
    output logic             data_line_out,
    output logic             data_line_oe_n,
    output logic             clock_line_out,
    output logic             clock_line_oe_n,
    output logic             gpio_mode_select
);

    logic [1:0]              pin_direction_reg;
    logic [1:0]              pin_drive_output_reg;
    logic [1:0]              pin_drive_output_next;
    logic                    gpio_mode_reg;
    logic [1:0]              pin_level_input;
    sbpg_pkg::sbpg_wr_t      wr_reg;
    sbpg_pkg::sbpg_sel_t     sel;
    sbpg_pkg::sbpg_pin_drv_t data_pin;
    sbpg_pkg::sbpg_pin_drv_t clock_pin;
    logic                    take;

    function automatic sbpg_pkg::sbpg_sel_t decode(input logic [7:0] a);
        sbpg_pkg::sbpg_sel_t s;
        s = sbpg_pkg::SBPG_SEL_NONE;
        unique case (a)
            sbpg_pkg::OFS_PIN_FUNCTION:  s = sbpg_pkg::SBPG_SEL_FUNCTION;
            sbpg_pkg::OFS_PIN_DIRECTION: s = sbpg_pkg::SBPG_SEL_DIRECTION;
            sbpg_pkg::OFS_PIN_LEVEL_IN:  s = sbpg_pkg::SBPG_SEL_LEVEL_IN;
            sbpg_pkg::OFS_PIN_DRIVE_OUT: s = sbpg_pkg::SBPG_SEL_DRIVE_OUT;
            sbpg_pkg::OFS_DRIVE_SET:     s = sbpg_pkg::SBPG_SEL_DRIVE_SET;
            sbpg_pkg::OFS_DRIVE_CLEAR:   s = sbpg_pkg::SBPG_SEL_DRIVE_CLEAR;
            default:                     s = sbpg_pkg::SBPG_SEL_NONE;
        endcase
        return s;
    endfunction

    // pin levels come from outside the clock domain
    sbpg_sync
    #(
        .WIDTH (2)
    )
    u_sync
    (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .async_in ({data_line_in, clock_line_in}),
        .sync_out (pin_level_input)
    );

    assign take = hsel && hready && htrans == sbpg_pkg::HTRANS_NONSEQ;
    assign sel  = (haddr[31:sbpg_pkg::ADDR_W] == '0 && haddr[1:0] == 2'h0)
                ? decode(haddr[7:0]) : sbpg_pkg::SBPG_SEL_NONE;

    // zero wait states, always okay
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // write data arrives a cycle after the address, so hold the target
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_reg.valid <= 1'b0;
            wr_reg.sel   <= sbpg_pkg::SBPG_SEL_NONE;
        end
        else if (hready)
        begin
            wr_reg.valid <= take && hwrite;
            wr_reg.sel   <= sel;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            gpio_mode_reg <= sbpg_pkg::RST_GPIO_MODE;
        else if (wr_reg.valid && wr_reg.sel == sbpg_pkg::SBPG_SEL_FUNCTION)
            gpio_mode_reg <= hwdata[sbpg_pkg::BIT_GPIO_MODE];
    end

    // only bits 1:0 are stored; upper write bits are dropped
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            pin_direction_reg <= sbpg_pkg::RST_DIRECTION;
        else if (wr_reg.valid && wr_reg.sel == sbpg_pkg::SBPG_SEL_DIRECTION)
            pin_direction_reg <= hwdata[1:0];
    end

    always_comb
    begin
        pin_drive_output_next = pin_drive_output_reg;
        if (wr_reg.valid)
        begin
            unique case (wr_reg.sel)
                sbpg_pkg::SBPG_SEL_DRIVE_OUT:
                    pin_drive_output_next = hwdata[1:0];
                sbpg_pkg::SBPG_SEL_DRIVE_SET:
                    pin_drive_output_next =
                        pin_drive_output_reg | hwdata[1:0];
                sbpg_pkg::SBPG_SEL_DRIVE_CLEAR:
                    pin_drive_output_next =
                        pin_drive_output_reg & ~hwdata[1:0];
                // level register and the rest ignore writes
                default:
                    pin_drive_output_next = pin_drive_output_reg;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            pin_drive_output_reg <= sbpg_pkg::RST_DRIVE;
        else
            pin_drive_output_reg <= pin_drive_output_next;
    end

    // aliases and unmapped addresses read zero
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if (take && !hwrite)
        begin
            unique case (sel)
                sbpg_pkg::SBPG_SEL_FUNCTION:
                    hrdata <= {31'h0, gpio_mode_reg};
                sbpg_pkg::SBPG_SEL_DIRECTION:
                    hrdata <= {30'h0, pin_direction_reg};
                sbpg_pkg::SBPG_SEL_LEVEL_IN:
                    hrdata <= {30'h0, pin_level_input};
                sbpg_pkg::SBPG_SEL_DRIVE_OUT:
                    hrdata <= {30'h0, pin_drive_output_reg};
                default:
                    hrdata <= 32'h0000_0000;
            endcase
        end
    end

    sbpg_pin_drv u_data_drv
    (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .gpio_mode (gpio_mode_reg),
        .dir_out   (pin_direction_reg[sbpg_pkg::BIT_DATA_LINE]),
        .drive_bit (pin_drive_output_reg[sbpg_pkg::BIT_DATA_LINE]),
        .pin       (data_pin)
    );

    sbpg_pin_drv u_clock_drv
    (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .gpio_mode (gpio_mode_reg),
        .dir_out   (pin_direction_reg[sbpg_pkg::BIT_CLOCK_LINE]),
        .drive_bit (pin_drive_output_reg[sbpg_pkg::BIT_CLOCK_LINE]),
        .pin       (clock_pin)
    );

    assign data_line_out   = data_pin.out;
    assign data_line_oe_n  = data_pin.oe_n;
    assign clock_line_out  = clock_pin.out;
    assign clock_line_oe_n = clock_pin.oe_n;

    // tells the bus engine to let go of the pins
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            gpio_mode_select <= sbpg_pkg::RST_GPIO_MODE;
        else
            gpio_mode_select <= gpio_mode_reg;
    end

endmodule

// ===== bench/sbpg_checker.sv
`timescale 1ns/1ns
module sbpg_checker
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        data_line_in,
    input wire logic        clock_line_in,
    input wire logic        data_line_out,
    input wire logic        data_line_oe_n,
    input wire logic        clock_line_out,
    input wire logic        clock_line_oe_n,
    input wire logic        gpio_mode_select
);
    logic [7:0] wsel;
    wire        take = hsel && hready && htrans == sbpg_pkg::HTRANS_NONSEQ;

    // address of the write in its data phase; ff is unmapped, so means none
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            wsel <= 8'hff;
        else
            wsel <= (take && hwrite) ? haddr[7:0] : 8'hff;
    end

    default clocking @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence wr_bit(logic [7:0] a, int b, logic v);
        wsel == a && hwdata[b] == v;
    endsequence
    // the pins pass a two-flop synchroniser, so only steady levels compare
    sequence pins_steady;
        $stable({data_line_in, clock_line_in}) [*4];
    endsequence

    level_read_a: assert property (
        pins_steady ##0 (take && !hwrite
            && haddr[7:0] == sbpg_pkg::OFS_PIN_LEVEL_IN)
        |=> hrdata[1:0] == $past({data_line_in, clock_line_in}))
        else $error("level read differs from pins");
    data_drive_a: assert property (
        !data_line_oe_n |-> gpio_mode_select)
        else $error("data line driven outside gpio mode");
    clock_drive_a: assert property (
        !clock_line_oe_n |-> gpio_mode_select)
        else $error("clock line driven outside gpio mode");
    mode_on_a: assert property (
        wr_bit(sbpg_pkg::OFS_PIN_FUNCTION, 0, 1'b1) |=> ##1 gpio_mode_select)
        else $error("gpio mode not entered");
    set_data_a: assert property (
        wr_bit(sbpg_pkg::OFS_DRIVE_SET, 1, 1'b1) |=> ##1 data_line_out)
        else $error("set alias missed data drive");
    clear_clock_a: assert property (
        wr_bit(sbpg_pkg::OFS_DRIVE_CLEAR, 0, 1'b1) |=> ##1 !clock_line_out)
        else $error("clear alias missed clock drive");
    dir_out_a: assert property (
        wr_bit(sbpg_pkg::OFS_PIN_DIRECTION, 1, 1'b1) ##0 gpio_mode_select
        ##1 gpio_mode_select |=> !data_line_oe_n)
        else $error("data line not driven as output");
    dir_in_a: assert property (
        wr_bit(sbpg_pkg::OFS_PIN_DIRECTION, 0, 1'b0) |=> ##1 clock_line_oe_n)
        else $error("clock line not released as input");
endmodule

bind sbpg_top sbpg_checker sbpg_checker_i (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .data_line_in(data_line_in), .clock_line_in(clock_line_in),
    .data_line_out(data_line_out), .data_line_oe_n(data_line_oe_n),
    .clock_line_out(clock_line_out), .clock_line_oe_n(clock_line_oe_n),
    .gpio_mode_select(gpio_mode_select));

// ===== bench/sbpg_bus_model.sv
`timescale 1ns/1ns
// pulled-up bus lines: outside devices can only pull low, so a released
// line shows high and a device holding low wins over a driven high
module sbpg_bus_model
(
    input  wire logic       data_line_out,
    input  wire logic       data_line_oe_n,
    input  wire logic       clock_line_out,
    input  wire logic       clock_line_oe_n,
    input  wire logic [1:0] hold_low,
    output logic            data_line_level,
    output logic            clock_line_level
);
    assign data_line_level  = (data_line_oe_n | data_line_out) & ~hold_low[1];
    assign clock_line_level = (clock_line_oe_n | clock_line_out)
                            & ~hold_low[0];
endmodule

// ===== bench/test_serial_bus_pin_gpio.sv
`timescale 1ns/1ns
module test_serial_bus_pin_gpio;
    localparam logic [7:0] FN  = sbpg_pkg::OFS_PIN_FUNCTION;
    localparam logic [7:0] DIR = sbpg_pkg::OFS_PIN_DIRECTION;
    localparam logic [7:0] LVL = sbpg_pkg::OFS_PIN_LEVEL_IN;
    localparam logic [7:0] OUT = sbpg_pkg::OFS_PIN_DRIVE_OUT;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0]  hold_low = 2'h0;
    logic [31:0] hrdata;
    logic        hreadyout, hresp, data_line_level, clock_line_level;
    logic        data_line_out, data_line_oe_n, clock_line_out;
    logic        clock_line_oe_n, gpio_mode_select;
    int          mismatches = 0;
    int          n_tests = 0;

    sbpg_top sbpg_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp),
        .data_line_in(data_line_level), .clock_line_in(clock_line_level),
        .data_line_out(data_line_out), .data_line_oe_n(data_line_oe_n),
        .clock_line_out(clock_line_out), .clock_line_oe_n(clock_line_oe_n),
        .gpio_mode_select(gpio_mode_select));
    sbpg_bus_model sbpg_bus_model_i (.data_line_out(data_line_out),
        .data_line_oe_n(data_line_oe_n), .clock_line_out(clock_line_out),
        .clock_line_oe_n(clock_line_oe_n), .hold_low(hold_low),
        .data_line_level(data_line_level),
        .clock_line_level(clock_line_level));

    initial
    begin
        forever #10 hclk = ~hclk;
    end

    task automatic report_and_stop;
        if (mismatches == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [31:0] d, output logic [31:0] r);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        hwrite <= w;
        hsize  <= sbpg_pkg::HSIZE_WORD;
        htrans <= sbpg_pkg::HTRANS_NONSEQ;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(a, 1'b1, d, r);
    endtask

    // upper bits read back zero and are not checked; only the two pin bits compare
    task automatic rd(input logic [7:0] a, input logic [1:0] e);
        logic [31:0] r;
        xfer(a, 1'b0, 32'h0, r);
        check({30'h0, r[1:0]}, {30'h0, e});
    endtask

    // pin outputs follow a register write one edge later; checked at the second falling edge
    task automatic pins(input logic [4:0] e);
        repeat (2) @(negedge hclk);
        check({27'h0, gpio_mode_select, data_line_oe_n, clock_line_oe_n,
               data_line_level, clock_line_level}, {27'h0, e});
    endtask

    task automatic reset_values;
        rd(DIR, 2'h0);
        rd(OUT, 2'h0);
        pins(5'h0f);
    endtask

    task automatic drive_aliases;
        wr(OUT, 32'hffff_fffe);
        rd(OUT, 2'h2);
        pins(5'h0f);
        wr(sbpg_pkg::OFS_DRIVE_SET, 32'h1);
        rd(OUT, 2'h3);
        wr(sbpg_pkg::OFS_DRIVE_CLEAR, 32'h2);
        rd(OUT, 2'h1);
        wr(sbpg_pkg::OFS_DRIVE_SET, 32'h0);
        wr(sbpg_pkg::OFS_DRIVE_CLEAR, 32'h0);
        rd(OUT, 2'h1);
        wr(DIR, 32'hffff_fffd);
        wr(8'h40, 32'hffff_ffff);
        rd(DIR, 2'h1);
    endtask

    task automatic gpio_pins;
        wr(FN, 32'h1);
        pins(5'h1b);
        wr(sbpg_pkg::OFS_DRIVE_CLEAR, 32'h1);
        pins(5'h1a);
        wr(DIR, 32'h2);
        pins(5'h15);
        wr(sbpg_pkg::OFS_DRIVE_SET, 32'h2);
        pins(5'h17);
    endtask

    task automatic level_input;
        @(posedge hclk);
        hold_low <= 2'h1;
        repeat (4) @(negedge hclk);
        rd(LVL, 2'h2);
        wr(LVL, 32'h1);
        rd(LVL, 2'h2);
        @(posedge hclk);
        hold_low <= 2'h3;
        repeat (4) @(negedge hclk);
        rd(LVL, 2'h0);
        rd(OUT, 2'h2);
        wr(FN, 32'h0);
        rd(LVL, 2'h0);
        @(posedge hclk);
        hold_low <= 2'h0;
        pins(5'h0f);
        rd(LVL, 2'h3);
    endtask

    initial
    begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        reset_values();
        drive_aliases();
        gpio_pins();
        level_input();
        report_and_stop();
    end

    initial
    begin
        repeat (3000) @(posedge hclk);
        mismatches++;
        report_and_stop();
    end
endmodule
